// *** rtl/tlic_pkg.sv ***
// package: constants, types and vector table of the two-level interrupt controller
`default_nettype none
package tlic_pkg;

  // ==========================================================================
  // register addresses and reset values
  localparam logic [7:0] INT_ON_ADDR        = 8'hA8;
  localparam logic [7:0] SEC_ON_LEVEL_ADDR  = 8'hA9;
  localparam logic [7:0] INT_LEVEL_ADDR     = 8'hB8;
  localparam logic [7:0] INT_ON_RESET       = 8'h00;
  localparam logic [7:0] SEC_ON_LEVEL_RESET = 8'hA0;
  localparam logic [7:0] INT_LEVEL_RESET    = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // ==========================================================================
  // field positions, interrupt enable register
  localparam int GLOBAL_GATE_BIT = 7;
  localparam int CONV_ON_BIT     = 6;
  localparam int T2_ON_BIT       = 5;
  localparam int UART_ON_BIT     = 4;
  localparam int T1_ON_BIT       = 3;
  localparam int EXT1_ON_BIT     = 2;
  localparam int T0_ON_BIT       = 1;
  localparam int EXT0_ON_BIT     = 0;
  // level register
  localparam int CONV_LVL_BIT    = 6;
  localparam int T2_LVL_BIT      = 5;
  localparam int UART_LVL_BIT    = 4;
  localparam int T1_LVL_BIT      = 3;
  localparam int EXT1_LVL_BIT    = 2;
  localparam int T0_LVL_BIT      = 1;
  localparam int EXT0_LVL_BIT    = 0;
  // secondary enable / level register
  localparam int SEC_FIXED_BIT   = 7;
  localparam int TII_LVL_BIT     = 6;
  localparam int PSM_LVL_BIT     = 5;
  localparam int SPI_LVL_BIT     = 4;
  localparam int TII_ON_BIT      = 2;
  localparam int PSM_ON_BIT      = 1;
  localparam int SPI_ON_BIT      = 0;

  // ==========================================================================
  // sources, index = polling rank (0 polled first)
  localparam int NSRC = 11;
  localparam logic [3:0] SRC_PSM  = 4'h0;
  localparam logic [3:0] SRC_WDT  = 4'h1;
  localparam logic [3:0] SRC_EXT0 = 4'h2;
  localparam logic [3:0] SRC_CONV = 4'h3;
  localparam logic [3:0] SRC_T0   = 4'h4;
  localparam logic [3:0] SRC_EXT1 = 4'h5;
  localparam logic [3:0] SRC_T1   = 4'h6;
  localparam logic [3:0] SRC_SPI  = 4'h7;
  localparam logic [3:0] SRC_UART = 4'h8;
  localparam logic [3:0] SRC_T2   = 4'h9;
  localparam logic [3:0] SRC_TII  = 4'hA;

  // ==========================================================================
  // types
  typedef struct packed {
    logic       supply_monitor_irq;
    logic       watchdog_irq;
    logic       ext0_flag;
    logic [1:0] converter_done_flags;
    logic       timer0_overflow;
    logic       ext1_flag;
    logic       timer1_overflow;
    logic [1:0] spi_i2c_flags;
    logic [1:0] uart_rx_tx_flags;
    logic [1:0] timer2_flags;
    logic       interval_timer_irq;
  } tlic_src_t;

  typedef struct packed {
    logic        req;
    logic        level;
    logic [3:0]  source;
    logic [15:0] vector;
  } tlic_grant_t;

  // in-service levels, gray along idle-low-both
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_LOW  = 2'b01,
    SVC_BOTH = 2'b11,
    SVC_HIGH = 2'b10
  } tlic_svc_t;

  // ==========================================================================
  // fixed vector of a source
  function automatic logic [15:0] tlic_vector(input logic [3:0] src);
    case (src)
      SRC_EXT0: tlic_vector = 16'h0003;
      SRC_T0:   tlic_vector = 16'h000B;
      SRC_EXT1: tlic_vector = 16'h0013;
      SRC_T1:   tlic_vector = 16'h001B;
      SRC_UART: tlic_vector = 16'h0023;
      SRC_T2:   tlic_vector = 16'h002B;
      SRC_CONV: tlic_vector = 16'h0033;
      SRC_SPI:  tlic_vector = 16'h003B;
      SRC_PSM:  tlic_vector = 16'h0043;
      SRC_TII:  tlic_vector = 16'h0053;
      SRC_WDT:  tlic_vector = 16'h005B;
      default:  tlic_vector = 16'h0000;
    endcase
  endfunction

endpackage
`default_nettype wire

// *** rtl/tlic_pick.sv ***
// fixed-order picker: lowest set index wins
`timescale 1ns/10ps
`default_nettype none
module tlic_pick
  import tlic_pkg::*;
#(
  parameter int N = NSRC
) (
  // candidates, bit 0 polled first
  input  wire logic [N-1:0] cand,
  // result
  output logic              found,
  output logic [3:0]        index
);

  always_comb begin
    found = 1'b0;
    index = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (cand[i]) begin
        found = 1'b1;
        index = 4'(i);
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/tlic_top.sv ***
// two-level interrupt controller: enables, levels, polling order, in-service tracking
// Functional notes
// - global gate bit 7 blocks every interrupt
// - enable bit 6 gates converter request
// - enable bit 5 gates Timer 2 request
// - enable bit 4 gates UART request
// - bits 3 and 1 gate Timer 1, 0
// - bits 2 and 0 gate external 1, 0
// - level register sets seven sources high/low
// - secondary bits 6,5,4 set three levels
// - secondary bits 2,1,0 gate three sources
// - high request pre-empts running low routine
// - simultaneous different levels: high goes first
// - same level never pre-empts running routine
// - equal level: fixed polling order decides
// - interval counter polled last, rank ten
// - accepted request loads its fixed vector
`timescale 1ns/10ps
`default_nettype none
module tlic_top
  import tlic_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // peripheral request flags
  input  wire tlic_src_t   src,
  // core handshake
  output logic             int_req,
  output logic      [15:0] int_vector,
  output logic             int_level,
  input  wire logic        int_ack,
  input  wire logic        int_reti,
  // in-service view
  output logic      [1:0]  in_service
);

  // ==========================================================================
  // registers
  logic [7:0] int_on_reg,       int_on_next;
  logic [7:0] int_level_reg,    int_level_next;
  logic [6:0] sec_reg,          sec_next;
  logic [7:0] rdata_reg,        rdata_next;

  always_comb begin
    int_on_next    = int_on_reg;
    int_level_next = int_level_reg;
    sec_next       = sec_reg;
    if (sfr_wr) begin
      case (sfr_addr)
        INT_ON_ADDR:       int_on_next    = sfr_wdata;
        INT_LEVEL_ADDR:    int_level_next = {1'b0, sfr_wdata[6:0]};
        SEC_ON_LEVEL_ADDR: sec_next       = sfr_wdata[6:0]; // bit 3 stored as written
        default:           ;
      endcase
    end
    case (sfr_addr)
      INT_ON_ADDR:       rdata_next = int_on_reg;
      INT_LEVEL_ADDR:    rdata_next = int_level_reg;
      SEC_ON_LEVEL_ADDR: rdata_next = {SEC_ON_LEVEL_RESET[SEC_FIXED_BIT], sec_reg};
      default:           rdata_next = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      int_on_reg    <= INT_ON_RESET;
      int_level_reg <= INT_LEVEL_RESET;
      sec_reg       <= SEC_ON_LEVEL_RESET[6:0];
      rdata_reg     <= READ_UNMAPPED;
    end else begin
      int_on_reg    <= int_on_next;
      int_level_reg <= int_level_next;
      sec_reg       <= sec_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;

  // ==========================================================================
  // request gating and level split, index = polling rank
  logic [NSRC-1:0] raw_req;
  logic [NSRC-1:0] src_on;
  logic [NSRC-1:0] src_high;
  logic [NSRC-1:0] cand_high;
  logic [NSRC-1:0] cand_low;

  always_comb begin
    raw_req = '0;
    src_on  = '0;
    src_high = '0;
    raw_req[SRC_PSM]  = src.supply_monitor_irq;
    raw_req[SRC_WDT]  = src.watchdog_irq;
    raw_req[SRC_EXT0] = src.ext0_flag;
    raw_req[SRC_CONV] = |src.converter_done_flags;
    raw_req[SRC_T0]   = src.timer0_overflow;
    raw_req[SRC_EXT1] = src.ext1_flag;
    raw_req[SRC_T1]   = src.timer1_overflow;
    raw_req[SRC_SPI]  = |src.spi_i2c_flags;
    raw_req[SRC_UART] = |src.uart_rx_tx_flags;
    raw_req[SRC_T2]   = |src.timer2_flags;
    raw_req[SRC_TII]  = src.interval_timer_irq;
    // watchdog has no enable or level bit: always on, always high
    src_on[SRC_WDT]   = 1'b1;
    src_high[SRC_WDT] = 1'b1;
    src_on[SRC_CONV]  = int_on_reg[CONV_ON_BIT];
    src_on[SRC_T2]    = int_on_reg[T2_ON_BIT];
    src_on[SRC_UART]  = int_on_reg[UART_ON_BIT];
    src_on[SRC_T1]    = int_on_reg[T1_ON_BIT];
    src_on[SRC_T0]    = int_on_reg[T0_ON_BIT];
    src_on[SRC_EXT1]  = int_on_reg[EXT1_ON_BIT];
    src_on[SRC_EXT0]  = int_on_reg[EXT0_ON_BIT];
    src_on[SRC_TII]   = sec_reg[TII_ON_BIT];
    src_on[SRC_PSM]   = sec_reg[PSM_ON_BIT];
    src_on[SRC_SPI]   = sec_reg[SPI_ON_BIT];
    src_high[SRC_CONV] = int_level_reg[CONV_LVL_BIT];
    src_high[SRC_T2]   = int_level_reg[T2_LVL_BIT];
    src_high[SRC_UART] = int_level_reg[UART_LVL_BIT];
    src_high[SRC_T1]   = int_level_reg[T1_LVL_BIT];
    src_high[SRC_EXT1] = int_level_reg[EXT1_LVL_BIT];
    src_high[SRC_T0]   = int_level_reg[T0_LVL_BIT];
    src_high[SRC_EXT0] = int_level_reg[EXT0_LVL_BIT];
    src_high[SRC_TII]  = sec_reg[TII_LVL_BIT];
    src_high[SRC_PSM]  = sec_reg[PSM_LVL_BIT];
    src_high[SRC_SPI]  = sec_reg[SPI_LVL_BIT];
    cand_high = (raw_req & src_on & src_high) & {NSRC{int_on_reg[GLOBAL_GATE_BIT]}};
    cand_low  = (raw_req & src_on & ~src_high) & {NSRC{int_on_reg[GLOBAL_GATE_BIT]}};
  end

  // ==========================================================================
  // polling within each level
  logic       high_found;
  logic [3:0] high_index;
  logic       low_found;
  logic [3:0] low_index;

  // rank order by index; watchdog index below external 0
  tlic_pick #(.N(NSRC)) u_pick_high (
    .cand  (cand_high),
    .found (high_found),
    .index (high_index)
  );

  tlic_pick #(.N(NSRC)) u_pick_low (
    .cand  (cand_low),
    .found (low_found),
    .index (low_index)
  );

  // ==========================================================================
  // arbitration and in-service tracking
  tlic_svc_t   svc_reg,   svc_next;
  tlic_grant_t grant_reg, grant_next;
  logic        high_busy;
  logic        low_busy;

  always_comb begin
    high_busy  = (svc_reg == SVC_HIGH) || (svc_reg == SVC_BOTH);
    low_busy   = (svc_reg != SVC_IDLE);
    grant_next = '0;
    if (high_found && !high_busy) begin
      // high wins over low and pre-empts a low routine
      grant_next.req    = 1'b1;
      grant_next.level  = 1'b1;
      grant_next.source = high_index;
    end else if (low_found && !low_busy) begin
      // a running routine blocks its own level
      grant_next.req    = 1'b1;
      grant_next.level  = 1'b0;
      grant_next.source = low_index;
    end
    grant_next.vector = tlic_vector(grant_next.source);
    // hold off one cycle while the in-service state moves
    if (int_ack || int_reti) begin
      grant_next.req = 1'b0;
    end

    svc_next = svc_reg;
    if (int_ack && grant_reg.req) begin
      case (svc_reg)
        SVC_IDLE: svc_next = grant_reg.level ? SVC_HIGH : SVC_LOW;
        SVC_LOW:  svc_next = grant_reg.level ? SVC_BOTH : SVC_LOW;
        default:  svc_next = svc_reg;
      endcase
    end else if (int_reti) begin
      case (svc_reg)
        SVC_BOTH: svc_next = SVC_LOW;
        SVC_HIGH: svc_next = SVC_IDLE;
        SVC_LOW:  svc_next = SVC_IDLE;
        default:  svc_next = SVC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      svc_reg   <= SVC_IDLE;
      grant_reg <= '0;
    end else begin
      svc_reg   <= svc_next;
      grant_reg <= grant_next;
    end
  end

  assign int_req    = grant_reg.req;
  assign int_vector = grant_reg.vector;
  assign int_level  = grant_reg.level;
  assign in_service = svc_reg;

endmodule
`default_nettype wire

// *** test/tlic_monitor.sv ***
// checker: request, level and in-service relations at the controller ports
`timescale 1ns/10ps
`default_nettype none
module tlic_monitor
  import tlic_pkg::*;
(
  // clock, reset, register port
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // requests and core handshake
  input wire tlic_src_t   src,
  input wire logic        int_req,
  input wire logic [15:0] int_vector,
  input wire logic        int_level,
  input wire logic        int_ack,
  input wire logic        int_reti,
  input wire logic [1:0]  in_service
);
  // ==========================================
  // register shadow and one-cycle-old copies
  logic [23:0] cfg_reg, cfg_p;
  tlic_src_t   src_p;
  logic [11:0] fl, en, lv;
  logic [3:0]  vi;
  always_ff @(posedge mclk) begin
    src_p <= src;
    cfg_p <= cfg_reg;
    if (!reset_n) cfg_reg <= {SEC_ON_LEVEL_RESET, INT_LEVEL_RESET, INT_ON_RESET};
    else if (sfr_wr && sfr_addr == INT_ON_ADDR) cfg_reg[7:0] <= sfr_wdata;
    else if (sfr_wr && sfr_addr == INT_LEVEL_ADDR) cfg_reg[15:8] <= sfr_wdata;
    else if (sfr_wr && sfr_addr == SEC_ON_LEVEL_ADDR) cfg_reg[23:16] <= sfr_wdata;
  end
  // flag, enable, level per vector slot
  assign vi = int_vector[6:3];
  assign fl = {src_p.watchdog_irq, src_p.interval_timer_irq, 1'b0, src_p.supply_monitor_irq,
    |src_p.spi_i2c_flags, |src_p.converter_done_flags, |src_p.timer2_flags, |src_p.uart_rx_tx_flags,
    src_p.timer1_overflow, src_p.ext1_flag, src_p.timer0_overflow, src_p.ext0_flag};
  assign en = {1'b1, cfg_p[18], 1'b0, cfg_p[17:16], cfg_p[6:0]};
  assign lv = {1'b1, cfg_p[22], 1'b0, cfg_p[21:20], cfg_p[14:8]};
  // ==========================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_gate_off: assert property (!cfg_p[7] |-> !int_req)
    else $error("request with gate off");
  a_src_enabled:
    assert property (int_req |-> vi < 4'hC && int_vector[15:7] == 9'h000 && int_vector[2:0] == 3'h3
      && fl[vi] && en[vi]) else $error("request from idle or disabled source");
  a_level_match: assert property (int_req |-> int_level == lv[vi])
    else $error("wrong request level");
  a_busy_hold:
    assert property (int_req && $past(in_service) != 2'b00 |-> int_level && $past(in_service) == 2'b01)
      else $error("request not above running level");
  a_wdt_first:
    assert property (int_req && src_p.watchdog_irq |-> int_vector inside {16'h005B, 16'h0043})
      else $error("watchdog passed over");
  a_ack_enter:
    assert property (int_ack && int_req && in_service == 2'b00 |=> in_service == ($past(int_level) ? 2'b10 : 2'b01))
      else $error("wrong level entered on ack");
  a_reti_inner: assert property (int_reti && in_service == 2'b11 |=> in_service == 2'b01)
    else $error("return did not leave high level");
  a_reti_idle: assert property (int_reti && in_service inside {2'b01, 2'b10} |=> in_service == 2'b00)
    else $error("return did not go idle");
endmodule
bind tlic_top tlic_monitor u_tlic_monitor (
  .mclk       (mclk),
  .reset_n    (reset_n),
  .sfr_addr   (sfr_addr),
  .sfr_wr     (sfr_wr),
  .sfr_wdata  (sfr_wdata),
  .sfr_rdata  (sfr_rdata),
  .src        (src),
  .int_req    (int_req),
  .int_vector (int_vector),
  .int_level  (int_level),
  .int_ack    (int_ack),
  .int_reti   (int_reti),
  .in_service (in_service)
);
`default_nettype wire

// *** test/tlic_core_model.sv ***
// core model: acknowledges a standing request after a chosen wait
`timescale 1ns/10ps
`default_nettype none
module tlic_core_model
  import tlic_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // controller side
  input  wire logic        int_req,
  input  wire logic [15:0] int_vector,
  output logic             int_ack,
  // bench control and report
  input  wire logic        ack_en,
  input  wire logic [1:0]  ack_wait,
  output logic             took,
  output logic      [15:0] took_vec
);
  int wait_cnt = 0;
  initial int_ack = 1'b0;
  initial took = 1'b0;
  always @(posedge mclk) begin
    if (int_ack) begin
      took_vec <= int_vector;
      int_ack  <= #1 1'b0;
      took     <= #1 1'b1;
    end else begin
      took <= #1 1'b0;
      if (reset_n && ack_en && int_req && wait_cnt >= ack_wait) begin
        int_ack  <= #1 1'b1;
        wait_cnt <= 0;
      end else if (ack_en && int_req) wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// testbench: random configuration and requests against a rank-ordered reference
`timescale 1ns/10ps
`default_nettype none
module tb
  import tlic_pkg::*;
;
  logic        mclk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, int_reti = 1'b0, ack_en = 1'b0;
  logic        int_req, int_level, int_ack, took, er, el, on, lv;
  logic [1:0]  in_service, ack_wait = 2'h0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, on_v, lvl_v, sec_v;
  logic [15:0] int_vector, took_vec, ev;
  logic [10:0] rq;
  logic [23:0] c;
  tlic_src_t   src = '0;
  int          fail_count = 0, cmp_count = 0, cyc = 0, svc = 0;
  int          en_pos[11] = '{17, -1, 0, 6, 1, 2, 3, 16, 4, 5, 18};
  int          lv_pos[11] = '{21, -1, 8, 14, 9, 10, 11, 20, 12, 13, 22};
  logic [15:0] vt[11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
                          16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  tlic_top u_tlic_top (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .sfr_addr   (sfr_addr),
    .sfr_wr     (sfr_wr),
    .sfr_wdata  (sfr_wdata),
    .sfr_rdata  (sfr_rdata),
    .src        (src),
    .int_req    (int_req),
    .int_vector (int_vector),
    .int_level  (int_level),
    .int_ack    (int_ack),
    .int_reti   (int_reti),
    .in_service (in_service)
  );
  tlic_core_model u_tlic_core_model (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .int_req    (int_req),
    .int_vector (int_vector),
    .int_ack    (int_ack),
    .ack_en     (ack_en),
    .ack_wait   (ack_wait),
    .took       (took),
    .took_vec   (took_vec)
  );
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    #1 sfr_addr = a;
    @(posedge mclk);
    #1 chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
  endtask
  // reference: high level first, then lowest rank
  task automatic check();
    repeat (2) @(posedge mclk);
    #1 rq = {src.interval_timer_irq, |src.timer2_flags, |src.uart_rx_tx_flags, |src.spi_i2c_flags,
      src.timer1_overflow, src.ext1_flag, src.timer0_overflow, |src.converter_done_flags,
      src.ext0_flag, src.watchdog_irq, src.supply_monitor_irq};
    c = {sec_v, lvl_v, on_v};
    er = 1'b0;
    for (int p = 1; p >= 0; p--) begin
      for (int k = 0; k < 11; k++) begin
        on = en_pos[k] < 0 ? 1'b1 : c[en_pos[k]];
        lv = lv_pos[k] < 0 ? 1'b1 : c[lv_pos[k]];
        if (!er && c[7] && rq[k] && on && lv == p[0] && (svc == 0 || (svc == 1 && lv))) begin
          er = 1'b1;
          el = lv;
          ev = vt[k];
        end
      end
    end
    chk("int_req", {15'h0, er}, {15'h0, int_req});
    if (er) chk("int_vector", ev, int_vector);
    if (er) chk("int_level", {15'h0, el}, {15'h0, int_level});
  endtask
  task automatic ack();
    ack_wait = 2'($urandom % 3);
    ack_en = 1'b1;
    for (int n = 0; n < 12 && !took; n++) begin
      @(posedge mclk);
      #2;
    end
    @(posedge mclk);
    #1 ack_en = 1'b0;
    svc = svc | (el ? 2 : 1);
    chk("took_vec", ev, took_vec);
    chk("in_service", 16'(svc), {14'h0, in_service});
  endtask
  task automatic reti();
    @(posedge mclk);
    #1 int_reti = 1'b1;
    @(posedge mclk);
    #1 int_reti = 1'b0;
    svc = svc[1] ? svc & 1 : 0;
    chk("in_service", 16'(svc), {14'h0, in_service});
  endtask
  initial begin
    void'($urandom(26846));
    repeat (8) @(posedge mclk);
    #1 reset_n = 1'b1;
    wr(8'hC4, 8'hFF);
    rd(8'hA8, 8'h00);
    rd(8'hA9, 8'hA0);
    rd(8'hB8, 8'h00);
    rd(8'hC4, 8'h00);
    for (int i = 0; i < 300; i++) begin
      on_v = 8'($urandom) | (i % 5 != 0 ? 8'h80 : 8'h00);
      lvl_v = 8'($urandom);
      sec_v = 8'($urandom) & 8'hF7;
      wr(INT_ON_ADDR, on_v);
      wr(INT_LEVEL_ADDR, lvl_v);
      wr(SEC_ON_LEVEL_ADDR, sec_v);
      if (i % 16 == 0) rd(INT_LEVEL_ADDR, lvl_v & 8'h7F);
      if (i % 16 == 0) rd(SEC_ON_LEVEL_ADDR, sec_v | 8'h80);
      src = tlic_src_t'(16'($urandom & $urandom));
      check();
      if (er) ack();
      src = tlic_src_t'(16'($urandom & $urandom));
      check();
      if (er) ack();
      while (svc != 0) reti();
    end
    wrap_up();
  end
endmodule
`default_nettype wire
